// ==== verilog/cbal_pkg.sv ====
// constants, register map and types for the cell balance and cell mask control block
package cbal_pkg;

	localparam int          NCELL          = 14;

	// register indices on the command link register port
	localparam logic [8:0]  ADDR_MASK      = 9'h040;
	localparam logic [8:0]  ADDR_SETUP     = 9'h013;
	localparam logic [8:0]  ADDR_CELLS     = 9'h014;
	localparam logic [8:0]  ADDR_TIMER     = 9'h015;
	localparam logic [8:0]  ADDR_DELTA     = 9'h016;
	localparam logic [8:0]  ADDR_STATUS    = 9'h017;

	// values after reset
	localparam logic [15:0] MASK_RST       = 16'h0000;
	localparam logic [15:0] SETUP_RST      = 16'h0000;
	localparam logic [13:0] CELLS_RST      = 14'h0000;
	localparam logic [15:0] TIMER_RST      = 16'h0000;
	localparam logic [7:0]  DELTA_RST      = 8'h00;

	// only inputs 2..14 (bits 1..13) can be masked
	localparam logic [15:0] MASK_VALID     = 16'h3ffe;
	// writable bits of the setup register: pause, internal select, mode
	localparam logic [15:0] SETUP_WMASK    = 16'h0303;

	// field positions
	localparam int          SETUP_INT_BIT  = 8;
	localparam int          SETUP_PAUSE_BIT = 9;

	// timing
	localparam int          CLK_NS         = 25;
	localparam int          PAUSE_MS       = 10;
	localparam int          PAUSE_CYC      = (PAUSE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int          TICK_MS        = 1;
	localparam int          TICK_CYC       = (TICK_MS * 1000000) / CLK_NS;
	localparam logic [7:0]  AUTO_PHASE_MS  = 8'h64;

	typedef enum logic [1:0]
	{
		CBAL_OFF    = 2'b00,
		CBAL_MANUAL = 2'b01,
		CBAL_TIMED  = 2'b10,
		CBAL_AUTO   = 2'b11
	} cbal_mode_e;

	typedef struct packed
	{
		logic [5:0] rsv_hi;
		logic       pause_on_scan;
		logic       internal_balance_select;
		logic [5:0] rsv_lo;
		cbal_mode_e mode;
	} cbal_setup_s;

	typedef enum logic [1:0]
	{
		SP_IDLE = 2'b00,
		SP_HOLD = 2'b01,
		SP_SCAN = 2'b10
	} cbal_scan_e;

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [8:0] addr;
		logic [15:0] wdata;
	} cbal_req_s;

endpackage

// ==== verilog/cbal_ctrl.sv ====
// cell balance drive, balance modes, scan pause and cell disable mask
//
// How it works
// RQ1: internal select 1 drives internal switches
// RQ2: internal select 0 drives external transistors; reset
// RQ3: pause-on-scan with continuous scan: off 10ms before
// RQ4: auto mode with pause-on-scan also suspends 10ms
// RQ5: after scan, balancing resumes as before
// RQ6: inhibit command stops balancing; enable resumes
// RQ7: manual mode outputs follow per-cell setup bits
// RQ8: timed mode: all outputs off at expiry
// RQ9: auto mode sequences cells until delta removed
// RQ10: mask bit kills fault detection and balancing
// RQ11: 16-bit mask at 9'h040, inputs 2..14
// RQ12: mask bit n-1 serves cell input n
// RQ13: readback skips masked cells, keeps order
// RQ14: after reset all outputs off, no mode active
`timescale 1ns/10ps

module cbal_ctrl
	import cbal_pkg::*;
#(
	parameter int PAUSE_CYC_P = PAUSE_CYC,
	parameter int TICK_CYC_P  = TICK_CYC
)
(
	input  wire logic              ref_clk,        // device clock, 40 MHz
	input  wire logic              arst_n,         // async reset, active low
	input  wire cbal_req_s         reg_req,        // register write/read request
	output logic [15:0]            reg_rdata,      // read data, valid cycle after rd
	input  wire logic              cmd_start,      // start timed or auto balance
	input  wire logic              cmd_inhibit,    // balance inhibit command
	input  wire logic              cmd_enable,     // balance enable command
	input  wire logic              scan_continuous, // scan engine in continuous mode
	input  wire logic              scan_req,       // scan engine wants to measure
	input  wire logic              scan_done,      // voltage scan finished
	output logic                   scan_go,        // pulse: measurement may begin
	output logic [NCELL-1:0]       balance_drive_output, // external transistor drive
	output logic [NCELL-1:0]       int_switch_on,  // internal balance switches
	output logic [NCELL-1:0]       detect_en,      // ov/uv/open-wire enable per input
	input  wire logic              rb_start,       // start cell readback ordering
	output logic                   rb_valid,       // readback entry present
	output logic [3:0]             rb_cell,        // cell sense input number 1..14
	output logic                   rb_last         // last enabled cell of readback
);

	////////////////////////////////////////////////////////////////////////////////
	// registers

	cbal_setup_s        setup_ff;
	logic [NCELL-1:0]   cells_ff;
	logic [15:0]        mask_ff;
	logic [15:0]        timer_ff;
	logic [7:0]         delta_ff;
	logic               setup_wr;
	logic [NCELL-1:0]   cell_en;

	assign setup_wr = reg_req.wr && (reg_req.addr == ADDR_SETUP);
	// bit k of the mask belongs to input k+1
	assign cell_en  = ~(mask_ff[NCELL-1:0] & MASK_VALID[NCELL-1:0]); // RQ12 RQ10

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			setup_ff <= cbal_setup_s'(SETUP_RST); // RQ2 RQ14
			cells_ff <= CELLS_RST;
			mask_ff  <= MASK_RST;
			timer_ff <= TIMER_RST;
			delta_ff <= DELTA_RST;
		end
		else if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				ADDR_SETUP: setup_ff <= cbal_setup_s'(reg_req.wdata & SETUP_WMASK);
				ADDR_CELLS: cells_ff <= reg_req.wdata[NCELL-1:0];
				ADDR_MASK:  mask_ff  <= reg_req.wdata; // RQ11
				ADDR_TIMER: timer_ff <= reg_req.wdata;
				ADDR_DELTA: delta_ff <= reg_req.wdata[7:0];
				default:    ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// commands, tick and run state

	logic               inhibit_ff;
	logic               run_ff;
	logic [15:0]        tick_cnt_ff;
	logic               tick;
	logic [15:0]        tmr_left_ff;
	logic               auto_done;
	logic               timed_run;
	logic               auto_run;

	assign tick      = (tick_cnt_ff == 16'(TICK_CYC_P - 1));
	assign timed_run = run_ff && (setup_ff.mode == CBAL_TIMED);
	assign auto_run  = run_ff && (setup_ff.mode == CBAL_AUTO);

	// inhibit wins over enable in the same cycle, the safe direction
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			inhibit_ff <= 1'b0;
		else if (cmd_inhibit)
			inhibit_ff <= 1'b1; // RQ6
		else if (cmd_enable)
			inhibit_ff <= 1'b0; // RQ6
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_ff <= 16'h0000;
		else if (tick)
			tick_cnt_ff <= 16'h0000;
		else
			tick_cnt_ff <= tick_cnt_ff + 16'h0001;
	end

	// any rewrite of the setup register stops a run; host must start again
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			run_ff <= 1'b0; // RQ14
		else if (setup_wr)
			run_ff <= 1'b0;
		else if (cmd_start && setup_ff.mode == CBAL_TIMED)
			run_ff <= (timer_ff != 16'h0000);
		else if (cmd_start && setup_ff.mode == CBAL_AUTO)
			run_ff <= (delta_ff != 8'h00);
		else if (timed_run && tick && tmr_left_ff == 16'h0001)
			run_ff <= 1'b0; // RQ8
		else if (auto_run && auto_done)
			run_ff <= 1'b0; // RQ9
	end

	// duration in ms; keeps running through scan pauses and inhibit
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			tmr_left_ff <= 16'h0000;
		else if (cmd_start && setup_ff.mode == CBAL_TIMED)
			tmr_left_ff <= timer_ff; // RQ8
		else if (timed_run && tick)
			tmr_left_ff <= tmr_left_ff - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// auto balance: odd and even cells alternate, never two neighbours at once

	logic               phase_ff;
	logic [7:0]         phase_ms_ff;
	logic               phase_end;
	logic [7:0]         rem_ff [NCELL];
	logic [NCELL-1:0]   rem_zero;
	logic [NCELL-1:0]   auto_drv;
	logic               gate_ff;
	logic               bal_block;

	assign phase_end = auto_run && tick && (phase_ms_ff == AUTO_PHASE_MS - 8'h01);
	assign auto_done = &rem_zero;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_ff    <= 1'b0;
			phase_ms_ff <= 8'h00;
		end
		else if (!auto_run)
		begin
			phase_ff    <= 1'b0;
			phase_ms_ff <= 8'h00;
		end
		else if (phase_end)
		begin
			phase_ff    <= ~phase_ff;
			phase_ms_ff <= 8'h00;
		end
		else if (tick)
			phase_ms_ff <= phase_ms_ff + 8'h01;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCELL; gi++)
		begin : g_cell
			assign rem_zero[gi] = (rem_ff[gi] == 8'h00);
			assign auto_drv[gi] = !rem_zero[gi] && (phase_ff == 1'(gi % 2));

			// charge is counted only for phases the cell was really driven
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
					rem_ff[gi] <= 8'h00;
				else if (cmd_start && setup_ff.mode == CBAL_AUTO)
					rem_ff[gi] <= (cells_ff[gi] && cell_en[gi]) ? delta_ff : 8'h00; // RQ9
				else if (setup_wr || !cell_en[gi])
					rem_ff[gi] <= 8'h00; // RQ10
				else if (phase_end && auto_drv[gi] && !bal_block)
					rem_ff[gi] <= rem_ff[gi] - 8'h01; // RQ9
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// scan pause: balancing off a full 10 ms before the measurement starts

	cbal_scan_e         scan_st_ff;
	logic [19:0]        pause_cnt_ff;
	logic               bal_any;
	logic               need_pause;
	logic [NCELL-1:0]   drv_raw;
	logic [NCELL-1:0]   drv_final;

	assign bal_any    = (setup_ff.mode == CBAL_MANUAL) || run_ff;
	assign need_pause = setup_ff.pause_on_scan && bal_any &&
	                    (scan_continuous || setup_ff.mode == CBAL_AUTO); // RQ3 RQ4
	assign bal_block  = inhibit_ff || gate_ff;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scan_st_ff   <= SP_IDLE;
			pause_cnt_ff <= 20'h00000;
			gate_ff      <= 1'b0;
			scan_go      <= 1'b0;
		end
		else
		begin
			scan_go <= 1'b0;
			unique case (scan_st_ff)
				SP_IDLE:
				begin
					if (scan_req && need_pause)
					begin
						scan_st_ff   <= SP_HOLD;
						gate_ff      <= 1'b1; // RQ3 RQ4
						// full count: drives go off one edge after the gate
						pause_cnt_ff <= 20'(PAUSE_CYC_P);
					end
					else if (scan_req)
					begin
						scan_st_ff <= SP_SCAN;
						scan_go    <= 1'b1;
					end
				end
				SP_HOLD:
				begin
					if (pause_cnt_ff == 20'h00000)
					begin
						scan_st_ff <= SP_SCAN;
						scan_go    <= 1'b1; // RQ3
					end
					else
						pause_cnt_ff <= pause_cnt_ff - 20'h00001;
				end
				SP_SCAN:
				begin
					if (scan_done)
					begin
						scan_st_ff <= SP_IDLE;
						gate_ff    <= 1'b0; // RQ5
					end
				end
				default:
				begin
					scan_st_ff <= SP_IDLE;
					gate_ff    <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// balance drive

	always_comb
	begin
		unique case (setup_ff.mode)
			CBAL_MANUAL: drv_raw = cells_ff; // RQ7
			CBAL_TIMED:  drv_raw = timed_run ? cells_ff : '0; // RQ8
			CBAL_AUTO:   drv_raw = auto_run ? auto_drv : '0; // RQ9
			CBAL_OFF:    drv_raw = '0; // RQ14
		endcase
	end

	// mode state is kept under the gate, so removing it restores the prior state
	assign drv_final = bal_block ? '0 : (drv_raw & cell_en); // RQ5 RQ6 RQ10

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			balance_drive_output <= '0; // RQ14
			int_switch_on        <= '0;
			detect_en            <= '1;
		end
		else
		begin
			int_switch_on        <= setup_ff.internal_balance_select ? drv_final : '0; // RQ1
			balance_drive_output <= setup_ff.internal_balance_select ? '0 : drv_final; // RQ2
			detect_en            <= cell_en; // RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register readback

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 16'h0000;
		else if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				ADDR_SETUP:  reg_rdata <= setup_ff;
				ADDR_CELLS:  reg_rdata <= {2'b00, cells_ff};
				ADDR_MASK:   reg_rdata <= mask_ff;
				ADDR_TIMER:  reg_rdata <= timer_ff;
				ADDR_DELTA:  reg_rdata <= {8'h00, delta_ff};
				ADDR_STATUS: reg_rdata <= {12'h000, phase_ff, gate_ff, inhibit_ff, run_ff};
				default:     reg_rdata <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// readback order: one candidate cell per cycle, masked ones dropped

	logic               rb_busy_ff;
	logic [3:0]         rb_idx_ff;
	logic [NCELL-1:0]   rb_above;

	assign rb_above = cell_en >> rb_idx_ff >> 1;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rb_busy_ff <= 1'b0;
			rb_idx_ff  <= 4'h0;
			rb_valid   <= 1'b0;
			rb_cell    <= 4'h0;
			rb_last    <= 1'b0;
		end
		else
		begin
			rb_valid <= rb_busy_ff && cell_en[rb_idx_ff]; // RQ13
			rb_cell  <= rb_idx_ff + 4'h1;
			rb_last  <= rb_busy_ff && cell_en[rb_idx_ff] && (rb_above == '0);
			if (rb_start && !rb_busy_ff)
			begin
				rb_busy_ff <= 1'b1;
				rb_idx_ff  <= 4'h0;
			end
			else if (rb_busy_ff)
			begin
				rb_busy_ff <= (rb_idx_ff != 4'(NCELL - 1));
				rb_idx_ff  <= rb_idx_ff + 4'h1;
			end
		end
	end

endmodule

// ==== dv/cbal_ctrl_properties.sv ====
// port assertions for the cell balance control block
`timescale 1ns/10ps
module cbal_chk
	import cbal_pkg::*;
(
	input wire logic             ref_clk,              // clock
	input wire logic             arst_n,               // reset
	input wire logic             cmd_inhibit,          // inhibit pulse
	input wire logic             scan_go,              // go pulse
	input wire logic [NCELL-1:0] balance_drive_output, // external drive
	input wire logic [NCELL-1:0] int_switch_on,        // internal drive
	input wire logic [NCELL-1:0] detect_en,            // detection enable
	input wire logic             rb_valid,             // readback entry
	input wire logic [3:0]       rb_cell,              // readback cell
	input wire logic             rb_last               // readback end
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	property p_one_path;
		!(|int_switch_on && |balance_drive_output);
	endproperty
	a_one_path: assert property (p_one_path)
		else $error("both drive paths on");
	property p_masked_off;
		((balance_drive_output | int_switch_on) & ~detect_en) == 14'h0000;
	endproperty
	a_masked_off: assert property (p_masked_off)
		else $error("masked input balancing");
	property p_first_input;
		detect_en[0];
	endproperty
	a_first_input: assert property (p_first_input)
		else $error("input one masked");
	property p_inhibit;
		cmd_inhibit |-> ##2 (balance_drive_output == 14'h0000 && int_switch_on == 14'h0000);
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("inhibit left drive on");
	property p_go_pulse;
		scan_go |=> !scan_go;
	endproperty
	a_go_pulse: assert property (p_go_pulse)
		else $error("scan go too long");
	property p_rb_cell;
		rb_valid |-> rb_cell >= 4'h1 && rb_cell <= 4'he && detect_en[rb_cell - 4'h1];
	endproperty
	a_rb_cell: assert property (p_rb_cell)
		else $error("readback of masked cell");
	property p_rb_last;
		rb_last |-> rb_valid ##1 !rb_valid;
	endproperty
	a_rb_last: assert property (p_rb_last)
		else $error("readback end wrong");
	property p_reset;
		$rose(arst_n) |-> int_switch_on == 14'h0000 && balance_drive_output == 14'h0000 && !scan_go;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not idle after reset");
endmodule
bind cbal_ctrl cbal_chk chk_u (.ref_clk, .arst_n, .cmd_inhibit, .scan_go, .balance_drive_output,
	.int_switch_on, .detect_en, .rb_valid, .rb_cell, .rb_last);

// ==== dv/cbal_host.sv ====
// host model: register accesses, commands and scan engine pulses
`timescale 1ns/10ps
module cbal_host
	import cbal_pkg::*;
(
	input  wire logic ref_clk,         // clock
	output cbal_req_s reg_req,         // register request
	output logic      cmd_start,       // start
	output logic      cmd_inhibit,     // inhibit
	output logic      cmd_enable,      // enable
	output logic      scan_continuous, // continuous scan level
	output logic      scan_req,        // scan request
	output logic      scan_done,       // scan finished
	output logic      rb_start         // readback start
);
	logic [5:0] pl = 6'h00;
	logic       cont = 1'b0;
	initial reg_req = '0;
	assign {cmd_start, cmd_inhibit, cmd_enable, scan_req, scan_done, rb_start} = pl;
	assign scan_continuous = cont;
	// held from one falling edge to the next, so exactly one rising edge takes it
	task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge ref_clk);
		reg_req = '0;
	endtask
	task automatic pulse(input logic [5:0] p);
		@(negedge ref_clk);
		pl = p;
		@(negedge ref_clk);
		pl = 6'h00;
	endtask
endmodule

// ==== dv/tb_cbal_ctrl.sv ====
// self-checking bench for the cell balance and cell mask control block
`timescale 1ns/10ps
module tb_cbal_ctrl
	import cbal_pkg::*;
;
	localparam int PC = 20;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	cbal_req_s reg_req;
	logic [15:0] reg_rdata, m;
	logic cmd_start, cmd_inhibit, cmd_enable, scan_continuous, scan_req, scan_done, rb_start;
	logic scan_go, rb_valid, rb_last, rd_d = 1'b0;
	logic [NCELL-1:0] balance_drive_output, int_switch_on, detect_en;
	logic [3:0] rb_cell;
	logic [15:0] exp_q[$];
	int fails = 0, total_checks = 0, cyc = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	cbal_host host_u (.ref_clk, .reg_req, .cmd_start, .cmd_inhibit, .cmd_enable,
		.scan_continuous, .scan_req, .scan_done, .rb_start);
	cbal_ctrl #(.PAUSE_CYC_P(PC), .TICK_CYC_P(8)) dut_u (.ref_clk, .arst_n, .reg_req, .reg_rdata,
		.cmd_start, .cmd_inhibit, .cmd_enable, .scan_continuous, .scan_req, .scan_done, .scan_go,
		.balance_drive_output, .int_switch_on, .detect_en, .rb_start, .rb_valid, .rb_cell, .rb_last);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic dv(input logic [13:0] e, input logic [13:0] i);
		chk({2'b00, balance_drive_output}, {2'b00, e});
		chk({2'b00, int_switch_on}, {2'b00, i});
	endtask
	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host_u.acc(1'b0, a, 16'h0000);
	endtask
	// outputs follow a write or command one edge after it is taken
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		host_u.acc(1'b1, a, d);
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic cmd(input logic [5:0] p);
		host_u.pulse(p);
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic scan_wait(input int e);
		int n;
		n = 0;
		host_u.pulse(6'h04);
		while (scan_go !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk);
			n++;
			if (n == 2 && e > 1)
				dv(14'h0000, 14'h0000);
		end
		chk(16'(n), 16'(e));
		cmd(6'h02);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (rd_d)
			chk(reg_rdata, exp_q.pop_front());
		if (rb_valid === 1'b1)
			chk({11'h000, rb_last, rb_cell}, exp_q.pop_front());
		rd_d <= reg_req.rd;
		if (cyc == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		void'($urandom(85));
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		dv(14'h0000, 14'h0000);
		chk({2'b00, detect_en}, 16'h3fff);
		rd(ADDR_MASK, MASK_RST);
		rd(ADDR_SETUP, SETUP_RST);
		wr(ADDR_SETUP, 16'h0001);
		wr(ADDR_CELLS, 16'h3fff);
		dv(14'h3fff, 14'h0000);
		wr(ADDR_SETUP, 16'h0101);
		dv(14'h0000, 14'h3fff);
		rd(ADDR_SETUP, 16'h0101);
		cmd(6'h10);
		dv(14'h0000, 14'h0000);
		rd(ADDR_STATUS, 16'h0002);
		cmd(6'h08);
		dv(14'h0000, 14'h3fff);
		rd(9'h1ff, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			m = (i == 0) ? 16'h0020 : (i == 1) ? 16'h01f8 : (i == 2) ? 16'hffff : 16'($urandom) & 16'h3ffe;
			wr(ADDR_MASK, m);
			dv(14'h0000, 14'h3fff & ~m[13:0] | 14'h0001);
			chk({2'b00, detect_en}, {2'b00, ~m[13:0] | 14'h0001});
			rd(ADDR_MASK, m);
			for (int k = 0; k < NCELL; k++)
				if (!m[k] || k == 0)
					exp_q.push_back(16'(k + 1));
			// highest enabled cell carries the end flag in bit 4
			exp_q[$] = exp_q[$] | 16'h0010;
			host_u.pulse(6'h01);
			repeat (20) @(negedge ref_clk);
		end
		wr(ADDR_MASK, 16'h0000);
		wr(ADDR_SETUP, 16'h0301);
		host_u.cont = 1'b1;
		scan_wait(PC + 1);
		dv(14'h0000, 14'h3fff);
		wr(ADDR_SETUP, 16'h0101);
		scan_wait(0);
		dv(14'h0000, 14'h3fff);
		wr(ADDR_TIMER, 16'h0003);
		rd(ADDR_TIMER, 16'h0003);
		wr(ADDR_CELLS, 16'h0005);
		wr(ADDR_SETUP, 16'h0102);
		cmd(6'h20);
		dv(14'h0000, 14'h0005);
		repeat (30) @(negedge ref_clk);
		dv(14'h0000, 14'h0000);
		host_u.cont = 1'b0;
		wr(ADDR_DELTA, 16'h0001);
		rd(ADDR_DELTA, 16'h0001);
		wr(ADDR_CELLS, 16'h0003);
		wr(ADDR_SETUP, 16'h0303);
		cmd(6'h20);
		chk({15'h0000, |int_switch_on}, 16'h0001);
		scan_wait(PC + 1);
		repeat (2000) @(negedge ref_clk);
		dv(14'h0000, 14'h0000);
		finish_test();
	end
endmodule
